// File: shared/sd_setup_pkg.sv
// Constants shared by the card-setup block: register offsets, field
// positions, reset values and cycle counts.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register port.
package sd_setup_pkg;
  // Clock rate and the settle time of the internal clock
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned CLK_SETTLE_NS = 1000;
  // Least time rounds up to whole cycles
  localparam int unsigned CLK_SETTLE_CYCLES = (CLK_SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;

  // Register byte offsets
  localparam logic [4:0] DEBOUNCE_CFG_OFS = 5'h00;  // vendor_debounce_cfg
  localparam logic [4:0] EVENT_FLAGS_OFS = 5'h04;   // normal_event_flags
  localparam logic [4:0] LATCH_MASK_OFS = 5'h08;    // normal_event_latch_mask
  localparam logic [4:0] ROUTE_MASK_OFS = 5'h0c;    // normal_event_route_mask
  localparam logic [4:0] PRESENT_OFS = 5'h10;       // present_state_view
  localparam logic [4:0] CLOCKING_OFS = 5'h14;      // clocking_control
  localparam logic [4:0] HOST_CTL_OFS = 5'h18;      // host control

  // Event bits, same place in flags, latch mask and route mask
  localparam int INSERT_BIT = 0;
  localparam int REMOVE_BIT = 1;
  localparam int CARD_IRQ_BIT = 8;
  localparam logic [8:0] EVENT_USED = 9'h103;

  // present_state_view bits
  localparam int PRESENT_BIT = 0;
  localparam int STABLE_VIEW_BIT = 1;
  localparam int RUNNING_BIT = 2;

  // clocking_control fields
  localparam int INT_CLK_EN_BIT = 0;
  localparam int CLK_STABLE_BIT = 1;
  localparam int DRIVE_ON_BIT = 2;
  localparam int DIV_PICK_LSB = 8;
  localparam int DIV_PICK_W = 8;

  // host control: data width select
  localparam int WIDTH4_BIT = 1;

  // Reset values
  localparam logic [15:0] DEBOUNCE_RESET = 16'h0400;
  localparam logic [8:0] MASK_RESET = 9'h000;
  localparam logic [DIV_PICK_W-1:0] DIV_PICK_RESET = 8'h00;
endpackage

// File: hw/card_detect_filter.sv
// Card-detect synchroniser and debounce filter.
// Assumes the detect pin is asynchronous to sys_clk and low while a card sits in the slot.
`timescale 1ns/1ns
module card_detect_filter (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic cardDetectN,
  input wire logic [15:0] debounceCycles,
  output logic present,
  output logic insertPulse,
  output logic removePulse
);
  logic sync1_q, sync2_q;         // Two-flop synchroniser
  logic level_q, level_d;         // Filtered presence
  logic [15:0] cnt_q, cnt_d;      // Cycles the raw level has differed
  logic ins_q, ins_d, rem_q, rem_d;

  // Count while the synchronised level differs; flip only after the interval
  always_comb begin
    level_d = level_q;
    cnt_d = 16'h0000;
    ins_d = 1'b0;
    rem_d = 1'b0;
    if (sync2_q != level_q) begin
      if (cnt_q >= debounceCycles) begin
        level_d = sync2_q;
        ins_d = sync2_q;
        rem_d = ~sync2_q;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  // Registers only; clock enable freezes everything
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      level_q <= 1'b0;
      cnt_q <= 16'h0000;
      ins_q <= 1'b0;
      rem_q <= 1'b0;
    end else if (clkEn) begin
      sync1_q <= ~cardDetectN;
      sync2_q <= sync1_q;
      level_q <= level_d;
      cnt_q <= cnt_d;
      ins_q <= ins_d;
      rem_q <= rem_d;
    end
  end

  assign present = level_q;
  assign insertPulse = ins_q;
  assign removePulse = rem_q;

  // A filtered change needs the full interval of a differing raw level
  a_debounce_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clkEn && $changed(level_q) |-> $past(cnt_q) >= $past(debounceCycles))
    else $error("presence changed before debounce interval");
endmodule

// File: hw/sd_host_card_setup.sv
// Card-setup part of an SD/SDIO/MMC host: card detect with sticky
// events, internal and card clock sequencing, and data width select.
// Assumes an Avalon-MM master on sys_clk and pins asynchronous to it.
// Summary of operation
// - Debounce card detect by a programmable interval
// - Detect flags clear on written one
// - Present bit reads one while card inserted
// - Clock-stable flag asserts once internal clock settles
// - Drive card clock only while enable set
// - Width bit selects 4-bit or 1-bit transfers
`timescale 1ns/1ns
module sd_host_card_setup #(
  parameter int unsigned SETTLE_CYCLES = sd_setup_pkg::CLK_SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cardDetectN,
  input wire logic cardIrqN,
  output logic cardClockPin,
  output logic dataWidth4,
  output logic eventIrq
);
  // Filtered presence and its edge pulses
  logic present, insertPulse, removePulse;
  // Card interrupt synchroniser; first stage feeds only the second
  logic irqSync1_q, irqSync2_q;
  // Bus handshake state
  logic waitReq_q, waitReq_d;
  logic [31:0] rdata_q, rdata_d;
  // Software-visible registers
  logic [15:0] debounce_q, debounce_d;
  logic [8:0] flags_q, flags_d;
  logic [8:0] latchMask_q, latchMask_d;
  logic [8:0] routeMask_q, routeMask_d;
  logic intClkEn_q, intClkEn_d;
  logic driveOn_q, driveOn_d;
  logic [sd_setup_pkg::DIV_PICK_W-1:0] divPick_q, divPick_d;
  logic width4_q, width4_d;
  // Clock machinery
  logic [15:0] settle_q, settle_d;   // Settle counter, saturates
  logic stable_q, stable_d;
  logic [sd_setup_pkg::DIV_PICK_W-1:0] divCnt_q, divCnt_d;
  logic cardClk_q, cardClk_d;
  logic irq_q, irq_d;
  // Decoded write taking effect this edge
  logic wrTake, rdTake;
  logic [8:0] setMask;
  logic [31:0] rview;

  card_detect_filter filter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .cardDetectN(cardDetectN),
    .debounceCycles(debounce_q),
    .present(present),
    .insertPulse(insertPulse),
    .removePulse(removePulse)
  );

  // A request is answered in its second cycle, when waitrequest is low
  assign wrTake = avs_write && !waitReq_q;
  assign rdTake = avs_read && waitReq_q;

  // Events only latch while their latch bit is allowed
  assign setMask = latchMask_q & {irqSync2_q, 6'h00, removePulse, insertPulse};

  // Read view of the addressed register; unmapped words read zero
  always_comb begin
    rview = 32'h0000_0000;
    case (avs_address)
      sd_setup_pkg::DEBOUNCE_CFG_OFS: rview[15:0] = debounce_q;
      sd_setup_pkg::EVENT_FLAGS_OFS: rview[8:0] = flags_q;
      sd_setup_pkg::LATCH_MASK_OFS: rview[8:0] = latchMask_q;
      sd_setup_pkg::ROUTE_MASK_OFS: rview[8:0] = routeMask_q;
      sd_setup_pkg::PRESENT_OFS: begin
        rview[sd_setup_pkg::PRESENT_BIT] = present;
        rview[sd_setup_pkg::STABLE_VIEW_BIT] = stable_q;
        rview[sd_setup_pkg::RUNNING_BIT] = cardClk_q | (driveOn_q & stable_q);
      end
      sd_setup_pkg::CLOCKING_OFS: begin
        rview[sd_setup_pkg::INT_CLK_EN_BIT] = intClkEn_q;
        rview[sd_setup_pkg::CLK_STABLE_BIT] = stable_q;
        rview[sd_setup_pkg::DRIVE_ON_BIT] = driveOn_q;
        rview[sd_setup_pkg::DIV_PICK_LSB +: sd_setup_pkg::DIV_PICK_W] = divPick_q;
      end
      sd_setup_pkg::HOST_CTL_OFS: rview[sd_setup_pkg::WIDTH4_BIT] = width4_q;
      default: rview = 32'h0000_0000;
    endcase
  end

  // Next values of bus, registers and clock machinery
  always_comb begin
    waitReq_d = 1'b1;
    rdata_d = rdata_q;
    debounce_d = debounce_q;
    latchMask_d = latchMask_q;
    routeMask_d = routeMask_q;
    intClkEn_d = intClkEn_q;
    driveOn_d = driveOn_q;
    divPick_d = divPick_q;
    width4_d = width4_q;
    // Set wins over a clear in the same cycle
    flags_d = flags_q | setMask;
    // Drop wait one cycle after a request appears
    if ((avs_read || avs_write) && waitReq_q) begin
      waitReq_d = 1'b0;
    end
    if (rdTake) begin
      rdata_d = rview;
    end
    if (wrTake) begin
      case (avs_address)
        sd_setup_pkg::DEBOUNCE_CFG_OFS: debounce_d = avs_writedata[15:0];
        sd_setup_pkg::EVENT_FLAGS_OFS: begin
          // Write one to clear, except bits set this very cycle
          flags_d = (flags_q & ~avs_writedata[8:0]) | setMask;
        end
        sd_setup_pkg::LATCH_MASK_OFS: latchMask_d = avs_writedata[8:0] & sd_setup_pkg::EVENT_USED;
        sd_setup_pkg::ROUTE_MASK_OFS: routeMask_d = avs_writedata[8:0] & sd_setup_pkg::EVENT_USED;
        sd_setup_pkg::CLOCKING_OFS: begin
          intClkEn_d = avs_writedata[sd_setup_pkg::INT_CLK_EN_BIT];
          driveOn_d = avs_writedata[sd_setup_pkg::DRIVE_ON_BIT];
          divPick_d = avs_writedata[sd_setup_pkg::DIV_PICK_LSB +: sd_setup_pkg::DIV_PICK_W];
        end
        sd_setup_pkg::HOST_CTL_OFS: width4_d = avs_writedata[sd_setup_pkg::WIDTH4_BIT];
        default: ;  // Unmapped writes are accepted and dropped
      endcase
    end
    // Internal clock settles a fixed time after it is enabled
    settle_d = 16'h0000;
    stable_d = 1'b0;
    if (intClkEn_q) begin
      if (settle_q >= 16'(SETTLE_CYCLES)) begin
        settle_d = settle_q;
        stable_d = 1'b1;
      end else begin
        settle_d = settle_q + 16'h0001;
      end
    end
    // Card clock: half period of pick+1 cycles; parks low when stopped.
    // Stopping mid-phase can shorten the last high phase; software must
    // stop the clock before a divider change to avoid a runt.
    divCnt_d = 8'h00;
    cardClk_d = 1'b0;
    if (driveOn_q && stable_q) begin
      cardClk_d = cardClk_q;
      divCnt_d = divCnt_q + 8'h01;
      if (divCnt_q >= divPick_q) begin
        divCnt_d = 8'h00;
        cardClk_d = ~cardClk_q;
      end
    end
    // Interrupt line follows flags that are both latched and routed
    irq_d = |(flags_q & routeMask_q);
  end

  // Registers only; clock enable freezes all state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqSync1_q <= 1'b0;
      irqSync2_q <= 1'b0;
      waitReq_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      debounce_q <= sd_setup_pkg::DEBOUNCE_RESET;
      flags_q <= 9'h000;
      latchMask_q <= sd_setup_pkg::MASK_RESET;
      routeMask_q <= sd_setup_pkg::MASK_RESET;
      intClkEn_q <= 1'b0;
      driveOn_q <= 1'b0;
      divPick_q <= sd_setup_pkg::DIV_PICK_RESET;
      width4_q <= 1'b0;
      settle_q <= 16'h0000;
      stable_q <= 1'b0;
      divCnt_q <= 8'h00;
      cardClk_q <= 1'b0;
      irq_q <= 1'b0;
    end else if (clkEn) begin
      irqSync1_q <= ~cardIrqN;
      irqSync2_q <= irqSync1_q;
      waitReq_q <= waitReq_d;
      rdata_q <= rdata_d;
      debounce_q <= debounce_d;
      flags_q <= flags_d;
      latchMask_q <= latchMask_d;
      routeMask_q <= routeMask_d;
      intClkEn_q <= intClkEn_d;
      driveOn_q <= driveOn_d;
      divPick_q <= divPick_d;
      width4_q <= width4_d;
      settle_q <= settle_d;
      stable_q <= stable_d;
      divCnt_q <= divCnt_d;
      cardClk_q <= cardClk_d;
      irq_q <= irq_d;
    end
  end

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdata_q;
  assign cardClockPin = cardClk_q;
  assign dataWidth4 = width4_q;
  assign eventIrq = irq_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Write of one to the insertion flag with no new insertion
  sequence clearInsert;
    clkEn && wrTake && avs_address == sd_setup_pkg::EVENT_FLAGS_OFS
      && avs_writedata[0] && !setMask[0];
  endsequence

  a_flag_sticky: assert property (
    clkEn && flags_q[0] && !(wrTake && avs_address == sd_setup_pkg::EVENT_FLAGS_OFS
      && avs_writedata[0]) |=> flags_q[0])
    else $error("insertion flag dropped without a clear");
  a_flag_clear: assert property (clearInsert |=> !flags_q[0])
    else $error("insertion flag not cleared by write of one");
  a_set_wins: assert property (clkEn && setMask[1] |=> flags_q[1])
    else $error("removal event lost");
  a_irq_route: assert property (clkEn ##1 clkEn |->
    eventIrq == |($past(flags_q) & $past(routeMask_q)))
    else $error("interrupt does not follow routed flags");
  a_present_read: assert property (clkEn && rdTake
    && avs_address == sd_setup_pkg::PRESENT_OFS |=> avs_readdata[0] == $past(present))
    else $error("present bit read wrong");
  a_stable_wait: assert property (clkEn && $rose(stable_q) |->
    $past(intClkEn_q) && $past(settle_q) >= 16'(SETTLE_CYCLES))
    else $error("clock stable before settle time");
  a_clock_stops: assert property (clkEn && !driveOn_q |=> !cardClockPin)
    else $error("card clock runs while disabled");
  a_width_write: assert property (clkEn && wrTake
    && avs_address == sd_setup_pkg::HOST_CTL_OFS |=> dataWidth4 == $past(avs_writedata[1]))
    else $error("data width not taken from write");
endmodule

// File: tb/card_slot_model.sv
// Behavioural card in its slot: detect switch, card interrupt line, clock edge counter.
// Assumes the bench calls its tasks from the sys_clk domain; timing is in 160 ns steps.
`timescale 1ns/1ns
module card_slot_model (
  input wire logic sys_clk,
  input wire logic cardClockPin,
  output logic cardDetectN,
  output logic cardIrqN
);
  int clockEdges = 0; // Rising card clock edges since the bench last cleared it
  initial begin
    cardDetectN = 1'b1; // Empty slot: switch open, pulled high
    cardIrqN = 1'b1; // Interrupt line idles at its pull-up level
  end
  // The card only sees edges that the pin really drives
  always @(posedge cardClockPin) begin
    clockEdges++;
  end
  // Settle the detect switch at a new level
  task automatic setDetect(input logic level);
    @(posedge sys_clk);
    cardDetectN <= level;
  endtask
  // Contact bounce: a burst of the opposite level, in 160 ns steps
  task automatic bounce(input int steps);
    logic old;
    old = cardDetectN;
    @(posedge sys_clk);
    cardDetectN <= !old;
    repeat (steps * 16) @(posedge sys_clk);
    cardDetectN <= old;
  endtask
  // Card pulls its interrupt line low for a number of 160 ns steps
  task automatic pulseIrq(input int steps);
    @(posedge sys_clk);
    cardIrqN <= 1'b0;
    repeat (steps * 16) @(posedge sys_clk);
    cardIrqN <= 1'b1;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the card-setup block.
// Assumes the slot model and the shared package are compiled first.
`timescale 1ns/1ns
`define CHK(got, exp, msg) begin totalChecks++; if ((got) !== (exp)) begin errCount++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module tb_top;
  logic sys_clk, sys_rst, clkEn, avs_read, avs_write, cardDetectN, cardIrqN;
  logic avs_waitrequest, cardClockPin, dataWidth4, eventIrq;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] pick;
  logic w;
  int errCount = 0; // Mismatches seen
  int totalChecks = 0; // Comparisons made
  int n, ex;

  sd_host_card_setup #(.SETTLE_CYCLES(8)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cardDetectN(cardDetectN), .cardIrqN(cardIrqN),
    .cardClockPin(cardClockPin), .dataWidth4(dataWidth4), .eventIrq(eventIrq));
  card_slot_model slot (.sys_clk(sys_clk), .cardClockPin(cardClockPin),
    .cardDetectN(cardDetectN), .cardIrqN(cardIrqN));

  // 100 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run, the only exit
  task automatic endSim();
    if (errCount == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One Avalon transfer; a leading edge keeps release and next request apart
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      errCount++;
      endSim();
    end
    rd = avs_readdata; // Read data stand at the completing edge
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Read until a bit sets, bounded so a stuck flag cannot hang the run
  task automatic poll(input logic [4:0] a, input int b);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0);
      k++;
    end while (rd[b] !== 1'b1 && k < 40);
    // A bit that never sets is a mismatch and ends the run
    if (rd[b] !== 1'b1) begin
      errCount++;
      endSim();
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    void'($urandom(20));
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values, unmapped word included; a dropped write must not stick
    bus(1'b1, 5'h1c, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(i * 4), 32'h0);
      `CHK(rd, (i == 0) ? {16'h0, sd_setup_pkg::DEBOUNCE_RESET} : 32'h0, "reset value")
    end
    // Short debounce, events latched and routed
    bus(1'b1, sd_setup_pkg::DEBOUNCE_CFG_OFS, 32'd40);
    bus(1'b1, sd_setup_pkg::LATCH_MASK_OFS, 32'h103);
    bus(1'b1, sd_setup_pkg::ROUTE_MASK_OFS, 32'h103);
    // A 16-cycle bounce is shorter than the filter and must vanish
    slot.bounce(1);
    repeat (60) @(posedge sys_clk);
    bus(1'b0, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h0);
    `CHK(rd, 32'h0, "bounce passed filter")
    slot.setDetect(1'b0);
    n = 0;
    while (eventIrq !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(n > 41 && n < 60, 1'b1, "insert delay")
    // The timeout has been counted by the check above
    if (n >= 200) begin
      endSim();
    end
    bus(1'b0, sd_setup_pkg::PRESENT_OFS, 32'h0);
    `CHK(rd[0], 1'b1, "present bit")
    // Removal while insert is still pending: both stay set
    slot.setDetect(1'b1);
    poll(sd_setup_pkg::EVENT_FLAGS_OFS, 1);
    `CHK(rd, 32'h3, "sticky flags")
    bus(1'b1, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h1);
    bus(1'b0, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h0);
    `CHK(rd, 32'h2, "one-to-clear")
    bus(1'b1, sd_setup_pkg::ROUTE_MASK_OFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    `CHK(eventIrq, 1'b0, "unrouted flag raised line")
    bus(1'b1, sd_setup_pkg::ROUTE_MASK_OFS, 32'h103);
    repeat (2) @(posedge sys_clk);
    `CHK(eventIrq, 1'b1, "routed flag missing")
    bus(1'b1, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h2);
    repeat (2) @(posedge sys_clk);
    `CHK(eventIrq, 1'b0, "line after clear")
    // Card interrupt ignored while its latch is off, as during a width change
    bus(1'b1, sd_setup_pkg::LATCH_MASK_OFS, 32'h3);
    slot.pulseIrq(1);
    bus(1'b0, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h0);
    `CHK(rd, 32'h0, "masked card irq latched")
    bus(1'b1, sd_setup_pkg::LATCH_MASK_OFS, 32'h103);
    slot.pulseIrq(1);
    bus(1'b0, sd_setup_pkg::EVENT_FLAGS_OFS, 32'h0);
    `CHK(rd, 32'h100, "card irq flag")
    // Internal clock first, wait for stable, then drive the card clock
    pick = 8'($urandom_range(3, 0));
    bus(1'b1, sd_setup_pkg::CLOCKING_OFS, {16'h0, pick, 8'h01});
    bus(1'b0, sd_setup_pkg::CLOCKING_OFS, 32'h0);
    `CHK(rd[1], 1'b0, "stable too early")
    poll(sd_setup_pkg::CLOCKING_OFS, 1);
    `CHK(rd[1], 1'b1, "never stable")
    bus(1'b1, sd_setup_pkg::CLOCKING_OFS, {16'h0, pick, 8'h05});
    slot.clockEdges = 0;
    repeat (96) @(posedge sys_clk);
    ex = 96 / (2 * (int'(pick) + 1));
    `CHK(slot.clockEdges >= ex - 1 && slot.clockEdges <= ex + 1, 1'b1, "card clock rate")
    // Clock enable low freezes the divider, so the pin must not move
    clkEn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    slot.clockEdges = 0;
    repeat (40) @(posedge sys_clk);
    `CHK(slot.clockEdges, 0, "card clock ran while frozen")
    clkEn <= 1'b1;
    bus(1'b1, sd_setup_pkg::CLOCKING_OFS, {16'h0, pick, 8'h01});
    // An edge launched at the stopping write itself is not a late edge
    repeat (2) @(posedge sys_clk);
    slot.clockEdges = 0;
    repeat (40) @(posedge sys_clk);
    `CHK(slot.clockEdges == 0 && cardClockPin === 1'b0, 1'b1, "clock not stopped")
    // Width select, random sequence, card interrupt latch off around it
    bus(1'b1, sd_setup_pkg::LATCH_MASK_OFS, 32'h3);
    repeat (6) begin
      w = 1'($urandom_range(1, 0));
      bus(1'b1, sd_setup_pkg::HOST_CTL_OFS, {30'h0, w, 1'b0});
      @(posedge sys_clk);
      `CHK(dataWidth4, w, "width output")
    end
    bus(1'b1, sd_setup_pkg::LATCH_MASK_OFS, 32'h103);
    bus(1'b0, sd_setup_pkg::LATCH_MASK_OFS, 32'h0);
    `CHK(rd, 32'h103, "latch mask restore")
    endSim();
  end
endmodule
